// ===== dv/cpu_core_model.sv
// cpu_core_model: core taking offers and ending handlers
// assumes ack_en and ret_go change at the falling edge
`default_nettype none
module cpu_core_model
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic grant,
  input wire logic ack_en,
  input wire logic ret_go,
  output logic ack,
  output logic ret
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // one-cycle accept and return pulses
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      {ack, ret} <= 2'h0;
    else
      {ack, ret} <= {grant && ack_en && !ack, ret_go && !ret};
endmodule : cpu_core_model
`default_nettype wire

// ===== dv/irq_prio_chk_asserts.sv
// irq_prio_chk: port properties of the priority block
// assumes CLK_EN held high
`default_nettype none
module irq_prio_chk
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic SFR_WR,
  input wire logic GLOBAL_IRQ_GATE,
  input wire logic SELF_PROGRAMMING_HALT,
  input wire logic GRANT_ACK,
  input wire logic RETURN_DONE,
  input wire logic IRQ_GRANT,
  input wire logic [3:0] IRQ_SRC,
  input wire logic IRQ_LEVEL,
  input wire logic KEYPAD_REQ,
  input wire logic WAKE
);
  timeunit 1ns;
  timeprecision 1ns;
  // ====
  // in-service levels, bit 1 high
  logic [1:0] svc_reg;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  always_ff @(posedge SYS_CLK or negedge RSTN)
    if (!RSTN)
      svc_reg <= 2'h0;
    else if (GRANT_ACK && IRQ_GRANT)
      svc_reg[IRQ_LEVEL] <= 1'h1;
    else if (RETURN_DONE)
      svc_reg <= svc_reg[1] ? {1'h0, svc_reg[0]} : 2'h0;
  property p_wake; WAKE == KEYPAD_REQ; endproperty
  a_wake: assert property (p_wake) else $error("wake");
  property p_kgate; !GLOBAL_IRQ_GATE |=> !KEYPAD_REQ; endproperty
  a_kgate: assert property (p_kgate) else $error("keypad gate");
  property p_gate; !GLOBAL_IRQ_GATE |=> !IRQ_GRANT; endproperty
  a_gate: assert property (p_gate) else $error("gate");
  property p_halt; SELF_PROGRAMMING_HALT |=> !IRQ_GRANT; endproperty
  a_halt: assert property (p_halt) else $error("halt");
  property p_hisvc; svc_reg[1] |=> !IRQ_GRANT; endproperty
  a_hisvc: assert property (p_hisvc) else $error("high nest");
  property p_losvc; svc_reg[0] |=> !IRQ_GRANT || IRQ_LEVEL; endproperty
  a_losvc: assert property (p_losvc) else $error("low nest");
  property p_hold;
    KEYPAD_REQ && GLOBAL_IRQ_GATE && !$past(SFR_WR) |=> KEYPAD_REQ;
  endproperty
  a_hold: assert property (p_hold) else $error("flag hold");
  property p_src; IRQ_GRANT |-> IRQ_SRC < 4'hc; endproperty
  a_src: assert property (p_src) else $error("source");
endmodule : irq_prio_chk
bind irq_priority_keypad_match irq_prio_chk i_chk (.*);
`default_nettype wire

// ===== dv/tb_irq_priority_keypad_match.sv
// tb_irq_priority_keypad_match: register, arbiter and keypad tests
// assumes cpu_core_model and the bound checker
`default_nettype none
module tb_irq_priority_keypad_match;
  import irq_prio_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic SYS_CLK = 0, RSTN = 0, CLK_EN = 1, SFR_WR = 0, SFR_RD = 0;
  logic [7:0] SFR_ADDR = 0, SFR_WDATA = 0, SFR_RDATA, PORT_ZERO_PINS = 8'hff;
  logic [10:0] PERIPH_REQ = 0;
  logic [6:0] STD_ENABLE = 0;
  logic GLOBAL_IRQ_GATE = 0, SELF_PROGRAMMING_HALT = 0, GRANT_ACK, RETURN_DONE;
  logic IRQ_GRANT, IRQ_LEVEL, KEYPAD_REQ, WAKE, ack_en = 0, ret_go = 0;
  logic [3:0] IRQ_SRC;
  int num_errors = 0, checked = 0;
  always #50 SYS_CLK = ~SYS_CLK;
  irq_priority_keypad_match i_dut (.*);
  cpu_core_model i_core (.clk(SYS_CLK), .rst_n(RSTN), .grant(IRQ_GRANT),
    .ack_en(ack_en), .ret_go(ret_go), .ack(GRANT_ACK), .ret(RETURN_DONE));
  // ====
  // access tasks
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cyc(1);
    {SFR_WR, SFR_ADDR, SFR_WDATA} = {1'h1, a, d};
    cyc(1);
    SFR_WR = 1'h0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    cyc(1);
    {SFR_RD, SFR_ADDR} = {1'h1, a};
    cyc(1);
    SFR_RD = 1'h0;
    check(SFR_RDATA, exp);
  endtask : rd
  task automatic grant_is(input logic [3:0] s, input logic l);
    repeat (8)
      if (IRQ_GRANT !== 1'h1)
        cyc(1);
    check({2'h0, IRQ_GRANT, IRQ_LEVEL, IRQ_SRC}, {3'h1, l, s});
  endtask : grant_is
  task automatic ret_pulse;
    ret_go = 1'h1;
    cyc(1);
    ret_go = 1'h0;
    cyc(6);
  endtask : ret_pulse
  task automatic tally_and_finish;
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #2000000;
    num_errors++;
    tally_and_finish();
  end
  // ====
  // main sequence
  initial
  begin
    cyc(20);
    RSTN = 1'h1;
    rd(ADDR_KPATN, 8'hff);
    rd(ADDR_KMASK, 8'h00);
    rd(8'h00, 8'h00);
    wr(ADDR_PRIO_A, 8'hff);
    rd(ADDR_PRIO_A, 8'hff);
    wr(ADDR_PRIO_B, 8'hff);
    rd(ADDR_PRIO_B, 8'he1);
    wr(ADDR_PRIO_B, 8'h80);
    wr(ADDR_PRIO_A, 8'h02);
    wr(ADDR_AUXEN, 8'h80);
    {GLOBAL_IRQ_GATE, SELF_PROGRAMMING_HALT, STD_ENABLE} = {2'h3, 7'h7f};
    PERIPH_REQ = 11'h005;
    cyc(6);
    check({7'h0, IRQ_GRANT}, 8'h00);
    SELF_PROGRAMMING_HALT = 1'h0;
    grant_is(4'h0, 1'h0);
    PERIPH_REQ = 11'h003;
    cyc(3);
    grant_is(4'h1, 1'h1);
    PERIPH_REQ = 11'h101;
    cyc(3);
    grant_is(4'h8, 1'h1);
    PERIPH_REQ = 11'h001;
    cyc(3);
    ack_en = 1'h1;
    cyc(4);
    PERIPH_REQ = 11'h002;
    grant_is(4'h1, 1'h1);
    cyc(4);
    PERIPH_REQ = 11'h004;
    cyc(6);
    check({7'h0, IRQ_GRANT}, 8'h00);
    ret_pulse();
    check({7'h0, IRQ_GRANT}, 8'h00);
    ack_en = 1'h0;
    ret_pulse();
    grant_is(4'h2, 1'h0);
    PERIPH_REQ = 11'h000;
    wr(ADDR_AUXEN, 8'h20);
    wr(ADDR_KMASK, 8'h01);
    PORT_ZERO_PINS = 8'hfd;
    cyc(8);
    rd(ADDR_KCTRL, 8'h00);
    PORT_ZERO_PINS = 8'hfe;
    cyc(8);
    check({6'h0, WAKE, KEYPAD_REQ}, 8'h03);
    grant_is(4'ha, 1'h0);
    wr(ADDR_KCTRL, 8'h00);
    rd(ADDR_KCTRL, 8'h01);
    PORT_ZERO_PINS = 8'hff;
    cyc(6);
    rd(ADDR_KCTRL, 8'h01);
    wr(ADDR_KCTRL, 8'h00);
    rd(ADDR_KCTRL, 8'h00);
    wr(ADDR_KPATN, 8'hfe);
    wr(ADDR_KCTRL, 8'h02);
    wr(ADDR_KCTRL, 8'h02);
    rd(ADDR_KCTRL, 8'h02);
    GLOBAL_IRQ_GATE = 1'h0;
    PORT_ZERO_PINS = 8'hfe;
    cyc(8);
    rd(ADDR_KCTRL, 8'h03);
    check({7'h0, KEYPAD_REQ}, 8'h00);
    CLK_EN = 1'h0;
    wr(ADDR_KPATN, 8'h00);
    CLK_EN = 1'h1;
    rd(ADDR_KPATN, 8'hfe);
    tally_and_finish();
  end
endmodule : tb_irq_priority_keypad_match
`default_nettype wire

// ===== hw/irq_prio_pkg.sv
// irq_prio_pkg: register addresses, reset values, field positions and
// source indices for the priority and keypad-match block.
// assumes an 8-bit special function register port on the core side.
`default_nettype none
package irq_prio_pkg;
  // ==========================================================
  // register addresses
  localparam logic [7:0] ADDR_PRIO_B = 8'hae;
  localparam logic [7:0] ADDR_PRIO_A = 8'hb8;
  localparam logic [7:0] ADDR_KPATN = 8'hd5;
  localparam logic [7:0] ADDR_KCTRL = 8'hd6;
  localparam logic [7:0] ADDR_KMASK = 8'hd7;
  localparam logic [7:0] ADDR_AUXEN = 8'had;
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_PRIO = 8'h00;
  localparam logic [7:0] RST_KPATN = 8'hff;
  localparam logic [7:0] RST_KMASK = 8'h00;
  localparam logic [7:0] RST_AUXEN = 8'h00;
  // ==========================================================
  // field positions
  localparam int KCTRL_FLAG = 0;
  localparam int KCTRL_POL = 1;
  localparam int PRIOB_SPI = 0;
  localparam int PRIOB_KEY = 5;
  localparam int PRIOB_TWO = 6;
  localparam int PRIOB_USB = 7;
  localparam logic [7:0] PRIOB_USED = 8'he1;
  // ==========================================================
  // source indices, lowest index wins within a level
  localparam int NSRC = 12;
  localparam int SRC_KEY = 10;
  localparam logic [3:0] SRC_NONE = 4'hf;
  // level values
  localparam logic LVL_HIGH = 1'b1;
  localparam logic LVL_LOW = 1'b0;

  typedef enum {ST_IDLE, ST_LOW, ST_HIGH, ST_HIGH_OVER_LOW} nest_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef struct packed {
    logic [7:0] prio_a;
    logic [7:0] prio_b;
    logic [7:0] kpatn;
    logic [7:0] kmask;
    logic [7:0] auxen;
    logic kpol;
    logic kflag;
    logic [7:0] rdata;
    logic [23:0] pin_s;
    nest_t nest;
    logic [3:0] low_src;
    logic [3:0] high_src;
    logic [3:0] grant_src;
    logic grant;
    logic grant_lvl;
    logic key_req;
    logic wake;
  } state_t;
endpackage : irq_prio_pkg
`default_nettype wire

// ===== hw/irq_priority_keypad_match.sv
// irq_priority_keypad_match: two-level priority resolver with nesting
// and the keypad pattern-match interrupt source.
// assumes the core pulses GRANT_ACK and RETURN_DONE for one clock.
`default_nettype none
module irq_priority_keypad_match
  import irq_prio_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic CLK_EN,
  input wire logic SFR_WR,
  input wire logic SFR_RD,
  input wire logic [7:0] SFR_ADDR,
  input wire logic [7:0] SFR_WDATA,
  output logic [7:0] SFR_RDATA,
  input wire logic [7:0] PORT_ZERO_PINS,
  input wire logic [10:0] PERIPH_REQ,
  input wire logic [6:0] STD_ENABLE,
  input wire logic GLOBAL_IRQ_GATE,
  input wire logic SELF_PROGRAMMING_HALT,
  input wire logic GRANT_ACK,
  input wire logic RETURN_DONE,
  output logic IRQ_GRANT,
  output logic [3:0] IRQ_SRC,
  output logic IRQ_LEVEL,
  output logic KEYPAD_REQ,
  output logic WAKE
);
  // ==========================================================
  // state
  state_t s_reg;
  state_t s_next;
  sfr_req_t req;
  logic [7:0] pins;
  logic [7:0] pins_prev;
  logic match;
  logic [NSRC-1:0] raw_req;
  logic [NSRC-1:0] enab;
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] pend_hi;
  logic [NSRC-1:0] pend_lo;
  logic [3:0] pick_hi;
  logic [3:0] pick_lo;
  logic cur_high;
  logic busy_low;
  logic in_service;

  // pin settling, decode and arbitration helpers
  logic [7:0] pin_agree;
  logic pins_stable;
  logic wr_prio_a;
  logic wr_prio_b;
  logic wr_kpatn;
  logic wr_kmask;
  logic wr_auxen;
  logic wr_kctrl;
  logic [7:0] rd_val;
  logic offer_hi;
  logic offer_lo;
  logic hold_off;

  assign req = '{wr: SFR_WR, rd: SFR_RD, addr: SFR_ADDR, wdata: SFR_WDATA};
  assign pins = s_reg.pin_s[23:16];
  assign pins_prev = s_reg.pin_s[15:8];

  // ==========================================================
  // source tables
  // sources 0..7 follow the first register bit order, 8 usb, 9 two-wire,
  // 10 keypad, 11 spi; request 10 comes from the local flag
  always_comb
  begin
    lvl[7:0] = s_reg.prio_a;
    lvl[8] = s_reg.prio_b[PRIOB_USB];
    lvl[9] = s_reg.prio_b[PRIOB_TWO];
    lvl[10] = s_reg.prio_b[PRIOB_KEY];
    lvl[11] = s_reg.prio_b[PRIOB_SPI];

    enab[6:0] = STD_ENABLE;
    enab[7] = 1'b0;
    enab[8] = s_reg.auxen[PRIOB_USB];
    enab[9] = s_reg.auxen[PRIOB_TWO];
    enab[10] = s_reg.auxen[PRIOB_KEY];
    enab[11] = s_reg.auxen[PRIOB_SPI];

    raw_req[9:0] = PERIPH_REQ[9:0];
    raw_req[10] = s_reg.kflag;
    raw_req[11] = PERIPH_REQ[10];
  end

  genvar g;
  generate
    for (g = 0; g < NSRC; g++)
    begin : g_src
      assign pend[g] = raw_req[g] & enab[g] & GLOBAL_IRQ_GATE;
      assign pend_hi[g] = pend[g] & (lvl[g] == LVL_HIGH);
      assign pend_lo[g] = pend[g] & (lvl[g] == LVL_LOW);
    end
  endgenerate

  // ==========================================================
  // pin settling: a match counts only once stages two and three agree on all eight bits
  generate
    for (g = 0; g < 8; g++)
    begin : g_pin
      assign pin_agree[g] = (pins[g] == pins_prev[g]);
    end
  endgenerate
  assign pins_stable = &pin_agree;

  // lowest index wins, same order at both levels
  function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
    logic [3:0] r;
    r = SRC_NONE;
    for (int i = NSRC - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : first_set

  assign pick_hi = first_set(pend_hi);
  assign pick_lo = first_set(pend_lo);

  // ==========================================================
  // keypad comparison on synchronised pins
  always_comb
  begin
    if (s_reg.kpol)
    begin
      match = ((pins ^ s_reg.kpatn) & s_reg.kmask) == 8'h00;
    end
    else
    begin
      match = ((pins ^ s_reg.kpatn) & s_reg.kmask) != 8'h00;
    end
  end

  assign cur_high = (s_reg.nest == ST_HIGH) || (s_reg.nest == ST_HIGH_OVER_LOW);
  assign busy_low = (s_reg.nest == ST_LOW);
  assign in_service = (s_reg.nest != ST_IDLE);
  assign offer_hi = (pick_hi != SRC_NONE) && !cur_high;
  assign offer_lo = (pick_lo != SRC_NONE) && !in_service;
  assign hold_off = SELF_PROGRAMMING_HALT || RETURN_DONE;

  // ==========================================================
  // register write decode
  assign wr_prio_a = req.wr && (req.addr == ADDR_PRIO_A);
  assign wr_prio_b = req.wr && (req.addr == ADDR_PRIO_B);
  assign wr_kpatn = req.wr && (req.addr == ADDR_KPATN);
  assign wr_kmask = req.wr && (req.addr == ADDR_KMASK);
  assign wr_auxen = req.wr && (req.addr == ADDR_AUXEN);
  assign wr_kctrl = req.wr && (req.addr == ADDR_KCTRL);

  // ==========================================================
  // register read mux
  always_comb
  begin
    unique case (req.addr)
      ADDR_PRIO_A: rd_val = s_reg.prio_a;
      ADDR_PRIO_B: rd_val = s_reg.prio_b;
      ADDR_KPATN: rd_val = s_reg.kpatn;
      ADDR_KMASK: rd_val = s_reg.kmask;
      ADDR_AUXEN: rd_val = s_reg.auxen;
      ADDR_KCTRL: rd_val = {6'h00, s_reg.kpol, s_reg.kflag};
      default: rd_val = 8'h00;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    s_next = s_reg;
    // three-stage pin shift; a match only counts on settled bits
    s_next.pin_s = {s_reg.pin_s[15:0], PORT_ZERO_PINS};

    // register writes
    if (wr_prio_a)
    begin
      s_next.prio_a = req.wdata;
    end

    if (wr_prio_b)
    begin
      s_next.prio_b = req.wdata & PRIOB_USED;
    end

    if (wr_kpatn)
    begin
      s_next.kpatn = req.wdata;
    end

    if (wr_kmask)
    begin
      s_next.kmask = req.wdata;
    end

    if (wr_auxen)
    begin
      s_next.auxen = req.wdata & PRIOB_USED;
    end

    if (wr_kctrl)
    begin
      s_next.kpol = req.wdata[KCTRL_POL];
      if (!req.wdata[KCTRL_FLAG])
      begin
        s_next.kflag = 1'b0;
      end
    end
    if (match && pins_stable)
    begin
      s_next.kflag = 1'b1;
    end

    // register reads
    s_next.rdata = 8'h00;
    if (req.rd)
    begin
      s_next.rdata = rd_val;
    end

    // nesting on handler return
    if (RETURN_DONE)
    begin
      unique case (s_reg.nest)
        ST_HIGH_OVER_LOW: s_next.nest = ST_LOW;
        ST_HIGH, ST_LOW: s_next.nest = ST_IDLE;
        default: s_next.nest = ST_IDLE;
      endcase
    end
    // accepted grant opens a handler
    if (GRANT_ACK && s_reg.grant)
    begin
      s_next.grant = 1'b0;
      if (s_reg.grant_lvl == LVL_HIGH)
      begin
        s_next.high_src = s_reg.grant_src;
        s_next.nest = busy_low ? ST_HIGH_OVER_LOW : ST_HIGH;
      end
      else
      begin
        s_next.low_src = s_reg.grant_src;
        s_next.nest = ST_LOW;
      end
    end
    else if (hold_off)
    begin
      s_next.grant = 1'b0;
    end
    else
    begin
      // arbitration: offer the best request the current level allows
      s_next.grant = 1'b0;
      if (offer_hi)
      begin
        s_next.grant = 1'b1;
        s_next.grant_src = pick_hi;
        s_next.grant_lvl = LVL_HIGH;
      end
      else if (offer_lo)
      begin
        s_next.grant = 1'b1;
        s_next.grant_src = pick_lo;
        s_next.grant_lvl = LVL_LOW;
      end
      else
      begin
        s_next.grant_src = SRC_NONE;
      end
    end

    s_next.key_req = pend[SRC_KEY];
    s_next.wake = pend[SRC_KEY];
  end

  // ==========================================================
  // registers
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s_reg <= '{prio_a: RST_PRIO,
                 prio_b: RST_PRIO,
                 kpatn: RST_KPATN,
                 kmask: RST_KMASK,
                 auxen: RST_AUXEN,
                 kpol: 1'b0,
                 kflag: 1'b0,
                 rdata: 8'h00,
                 pin_s: 24'hffffff,
                 nest: ST_IDLE,
                 low_src: SRC_NONE,
                 high_src: SRC_NONE,
                 grant_src: SRC_NONE,
                 grant: 1'b0,
                 grant_lvl: 1'b0,
                 key_req: 1'b0,
                 wake: 1'b0};
    end
    else if (CLK_EN)
    begin
      s_reg <= s_next;
    end
  end

  // ==========================================================
  // outputs, each straight from the state register
  assign SFR_RDATA = s_reg.rdata;
  assign IRQ_GRANT = s_reg.grant;
  assign IRQ_SRC = s_reg.grant_src;
  assign IRQ_LEVEL = s_reg.grant_lvl;
  assign KEYPAD_REQ = s_reg.key_req;
  assign WAKE = s_reg.wake;
endmodule : irq_priority_keypad_match
`default_nettype wire
